// File: sdram_pin_map.vh
// Pin-level constants for the DDR3-style memory controller
`ifndef SDRAM_PIN_MAP_VH
`define SDRAM_PIN_MAP_VH
`define BANK_W        3
`define ADDR_W        15
`define COL_W         10
`define AUTO_CLOSE_BIT 10
`define SHORTEN_BIT   12
`define LANE_W        8
`define BEATS_FULL    4'h8
`define BEATS_CHOP    4'h4
// Command codes {cs_n, ras_n, cas_n, we_n}
`define CMD_DESEL     4'hF
`define CMD_NOP       4'h7
`define CMD_MRS       4'h0
`define CMD_ACT       4'h3
`define CMD_READ      4'h5
`define CMD_WRITE     4'h4
`define CMD_PRE       4'h2
// Link clock half period in core cycles
`define LINK_HALF     4'h6
// Core cycles the lanes stay active after a burst ends
`define TAIL_CYCLES   3'h4
`endif

// File: lane_beat.v
// One byte lane: write data, mask and strobe drive, read capture
`timescale 1ns/1ps
`default_nettype none
module lane_beat #(
	parameter W = 8
) (
	// Clock and reset
	input  wire         clk,
	input  wire         rst,
	// Beat control
	input  wire         wr_act,
	input  wire         rd_act,
	input  wire         beat_stb,
	input  wire [W-1:0] wr_data,
	input  wire         wr_keep,
	// Pins
	input  wire [W-1:0] dq_in,
	output reg  [W-1:0] dq_out,
	output reg          dq_oe,
	output reg          mask,
	input  wire         dqs_t_in,
	output reg          dqs_t_out,
	output reg          dqs_c_out,
	output reg          dqs_oe,
	// Read result
	output reg  [W-1:0] rd_data,
	output reg          rd_valid
);
	reg dqs_s1_ff, dqs_s2_ff, dqs_s3_ff;
	reg [W-1:0] dq_s1_ff, dq_s2_ff;
	// Synchronise read strobe and data
	always @(posedge clk) begin
		dqs_s1_ff <= dqs_t_in;
		dqs_s2_ff <= dqs_s1_ff;
		dqs_s3_ff <= dqs_s2_ff;
		dq_s1_ff  <= dq_in;
		dq_s2_ff  <= dq_s1_ff;
	end
	// Write drive: strobe toggles on every core cycle between beat slots, one mask per beat
	always @(posedge clk) begin
		if (rst) begin
			dq_out    <= {W{1'b0}};
			dq_oe     <= 1'b0;
			mask      <= 1'b0;
			dqs_t_out <= 1'b0;
			dqs_c_out <= 1'b1;
			dqs_oe    <= 1'b0;
		end else begin
			dq_oe  <= wr_act;
			dqs_oe <= wr_act;
			if (wr_act && beat_stb) begin
				dq_out <= wr_data;
				mask   <= ~wr_keep;
			end else if (wr_act) begin
				dqs_t_out <= ~dqs_t_out;
				dqs_c_out <= dqs_t_out;
			end else begin
				mask      <= 1'b0;
				dqs_t_out <= 1'b0;
				dqs_c_out <= 1'b1;
			end
		end
	end
	// Read capture on any strobe edge, edge-aligned data
	always @(posedge clk) begin
		if (rst) begin
			rd_data  <= {W{1'b0}};
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_act && (dqs_s2_ff != dqs_s3_ff);
			if (rd_act && (dqs_s2_ff != dqs_s3_ff))
				rd_data <= dq_s2_ff;
		end
	end
endmodule
`default_nettype wire

// File: sdram_host.v
// Controller driving command, address and two byte lanes of the memory
// Operation
// - Masks sampled on both strobe edges; one mask per beat.
// - Three bank bits pick bank for Active, Read, Write, Precharge.
// - Bank bits pick the mode register during Mode Register Set.
// - Active carries 15-bit row; Read/Write carry 10-bit column.
// - Address carries opcode during Mode Register Set.
// - Controller keeps reset deasserted in normal operation.
// - Strobes driven by device on reads, controller on writes.
// - Read strobe edge-aligned; write strobe centred in data eye (the lanes toggle it on every core cycle between beat slots).
// - Strobes are always differential true/complement pairs; the controller drives both on writes but takes only the true strobe on reads.
// - Data bus split into two lanes, own strobe and mask.
// - Commands sampled when true clock rises.
`timescale 1ns/1ps
`default_nettype none
`include "sdram_pin_map.vh"
module sdram_host #(
	parameter BW = 3,
	parameter AW = 15,
	parameter CW = 10
) (
	// Clock and reset
	input  wire          clk,
	input  wire          rst,
	// User request
	input  wire          req_valid,
	output wire          req_ready,
	input  wire [3:0]    req_cmd,
	input  wire [BW-1:0] req_bank,
	input  wire [AW-1:0] req_addr,
	input  wire          req_auto_close,
	input  wire          req_all_banks,
	input  wire          req_chop,
	input  wire          chop_enable,
	input  wire          dev_reset_req,
	// Write data per beat
	input  wire [15:0]   wdata,
	input  wire [1:0]    wkeep,
	output wire          wdata_take,
	// Read data per beat
	output wire [15:0]   rdata,
	output wire          rdata_valid,
	// Command pins
	output reg           link_clk_t,
	output reg           link_clk_c,
	output reg           cs_n,
	output reg           ras_n,
	output reg           cas_n,
	output reg           we_n,
	output reg  [BW-1:0] bank,
	output reg  [AW-1:0] addr,
	output reg           reset_n,
	// Lower lane pins
	input  wire [7:0]    lower_lane_data_in,
	output wire [7:0]    lower_lane_data_out,
	output wire          lower_lane_data_oe,
	output wire          lower_lane_write_mask,
	input  wire          lower_lane_strobe_in,
	output wire          lower_lane_strobe_t_out,
	output wire          lower_lane_strobe_c_out,
	output wire          lower_lane_strobe_oe,
	// Upper lane pins
	input  wire [7:0]    upper_lane_data_in,
	output wire [7:0]    upper_lane_data_out,
	output wire          upper_lane_data_oe,
	output wire          upper_lane_write_mask,
	input  wire          upper_lane_strobe_in,
	output wire          upper_lane_strobe_t_out,
	output wire          upper_lane_strobe_c_out,
	output wire          upper_lane_strobe_oe
);
	localparam S_IDLE  = 2'h0;
	localparam S_WRITE = 2'h1;
	localparam S_READ  = 2'h2;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [3:0] div_ff;
	reg [3:0] beats_ff;
	reg [2:0] tail_ff;
	reg       tail_rd_ff;

	// Command slot at each rising edge of the link clock
	wire rise_stb = (div_ff == `LINK_HALF - 4'h1) && !link_clk_t;
	wire fall_stb = (div_ff == `LINK_HALF - 4'h1) && link_clk_t;
	wire beat_stb = rise_stb | fall_stb;
	wire is_rw    = (req_cmd == `CMD_READ) || (req_cmd == `CMD_WRITE);
	wire [3:0] req_beats = (chop_enable && req_chop) ?
		`BEATS_CHOP : `BEATS_FULL;
	wire wr_act = (state_ff == S_WRITE);
	wire rd_act = (state_ff == S_READ);
	// Lanes stay active past the burst: the last write beat must stand a
	// whole beat, and read strobes arrive late through the synchroniser
	wire lane_wr = wr_act || (tail_ff != 3'h0 && !tail_rd_ff);
	wire lane_rd = rd_act || (tail_ff != 3'h0 && tail_rd_ff);

	// Requests enter at a fall slot, so pins settle before the rise
	assign req_ready  = (state_ff == S_IDLE) && fall_stb && !dev_reset_req;
	assign wdata_take = wr_act && beat_stb;

	// Link clock divider, differential
	always @(posedge clk) begin
		if (rst) begin
			div_ff     <= 4'h0;
			link_clk_t <= 1'b0;
			link_clk_c <= 1'b1;
		end else if (div_ff == `LINK_HALF - 4'h1) begin
			div_ff     <= 4'h0;
			link_clk_t <= ~link_clk_t;
			link_clk_c <= link_clk_t;
		end else begin
			div_ff <= div_ff + 4'h1;
		end
	end

	// Burst sequencing
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE: begin
				if (req_valid && req_ready && req_cmd == `CMD_WRITE)
					nxt_state = S_WRITE;
				else if (req_valid && req_ready && req_cmd == `CMD_READ)
					nxt_state = S_READ;
			end
			default: begin
				if (beat_stb && beats_ff == 4'h1)
					nxt_state = S_IDLE;
			end
		endcase
	end

	// Beat count and the short tail after each burst
	always @(posedge clk) begin
		if (rst) begin
			state_ff   <= S_IDLE;
			beats_ff   <= 4'h0;
			tail_ff    <= 3'h0;
			tail_rd_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (state_ff == S_IDLE && req_valid && req_ready && is_rw) begin
				beats_ff <= req_beats;
			end else if (state_ff != S_IDLE && beat_stb) begin
				beats_ff <= beats_ff - 4'h1;
			end
			if (state_ff != S_IDLE) begin
				tail_ff    <= `TAIL_CYCLES;
				tail_rd_ff <= rd_act;
			end else if (tail_ff != 3'h0) begin
				tail_ff <= tail_ff - 3'h1;
			end
		end
	end

	// Command and address drive, changed ahead of the rising edge
	always @(posedge clk) begin
		if (rst) begin
			{cs_n, ras_n, cas_n, we_n} <= `CMD_DESEL;
			bank    <= {BW{1'b0}};
			addr    <= {AW{1'b0}};
			reset_n <= 1'b0;
		end else begin
			reset_n <= ~dev_reset_req;
			if (req_valid && req_ready) begin
				{cs_n, ras_n, cas_n, we_n} <= req_cmd;
				bank <= req_bank;
				addr <= req_addr;
				if (is_rw) begin
					addr <= {AW{1'b0}};
					addr[CW-1:0] <= req_addr[CW-1:0];
					addr[`AUTO_CLOSE_BIT] <= req_auto_close;
					addr[`SHORTEN_BIT] <= ~(chop_enable && req_chop);
				end else if (req_cmd == `CMD_PRE) begin
					addr[`AUTO_CLOSE_BIT] <= req_all_banks;
				end
			end else if (fall_stb) begin
				{cs_n, ras_n, cas_n, we_n} <= `CMD_DESEL;
			end
		end
	end

	// Two byte lanes on shared beat controls; rdata_valid comes from the lower lane only
	lane_beat #(.W(8)) u_lower (
		.clk      (clk),
		.rst      (rst),
		.wr_act   (lane_wr),
		.rd_act   (lane_rd),
		.beat_stb (beat_stb),
		.wr_data  (wdata[7:0]),
		.wr_keep  (wkeep[0]),
		.dq_in    (lower_lane_data_in),
		.dq_out   (lower_lane_data_out),
		.dq_oe    (lower_lane_data_oe),
		.mask     (lower_lane_write_mask),
		.dqs_t_in (lower_lane_strobe_in),
		.dqs_t_out(lower_lane_strobe_t_out),
		.dqs_c_out(lower_lane_strobe_c_out),
		.dqs_oe   (lower_lane_strobe_oe),
		.rd_data  (rdata[7:0]),
		.rd_valid (rdata_valid)
	);
	lane_beat #(.W(8)) u_upper (
		.clk      (clk),
		.rst      (rst),
		.wr_act   (lane_wr),
		.rd_act   (lane_rd),
		.beat_stb (beat_stb),
		.wr_data  (wdata[15:8]),
		.wr_keep  (wkeep[1]),
		.dq_in    (upper_lane_data_in),
		.dq_out   (upper_lane_data_out),
		.dq_oe    (upper_lane_data_oe),
		.mask     (upper_lane_write_mask),
		.dqs_t_in (upper_lane_strobe_in),
		.dqs_t_out(upper_lane_strobe_t_out),
		.dqs_c_out(upper_lane_strobe_c_out),
		.dqs_oe   (upper_lane_strobe_oe),
		.rd_data  (rdata[15:8]),
		.rd_valid ()
	);
endmodule
`default_nettype wire

// File: sdram_host_properties.sv
// Pin behaviour checks for the memory controller
`timescale 1ns/1ps
`default_nettype none
`include "sdram_pin_map.vh"
module sdram_host_properties #(
	parameter BW = 3,
	parameter AW = 15
) (
	// Clock, reset and user side
	input wire          clk,
	input wire          rst,
	input wire          req_valid,
	input wire          req_ready,
	input wire [3:0]    req_cmd,
	input wire [BW-1:0] req_bank,
	input wire [AW-1:0] req_addr,
	input wire          req_auto_close,
	input wire          req_all_banks,
	input wire          req_chop,
	input wire          chop_enable,
	input wire          dev_reset_req,
	input wire [1:0]    wkeep,
	input wire          wdata_take,
	// Pins
	input wire          cs_n,
	input wire          ras_n,
	input wire          cas_n,
	input wire          we_n,
	input wire [BW-1:0] bank,
	input wire [AW-1:0] addr,
	input wire          reset_n,
	input wire          lower_lane_write_mask,
	input wire          upper_lane_write_mask
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Taken requests and the column kinds among them
	wire go = req_valid && req_ready;
	wire rw = go && req_cmd[3:1] == 3'h2;
	wire chop = chop_enable && req_chop;
	cmd_code_a: assert property (go |=>
		{cs_n, ras_n, cas_n, we_n} == $past(req_cmd)) else $error("cmd wrong");
	bank_sel_a: assert property (go |=>
		bank == $past(req_bank)) else $error("bank wrong");
	row_code_a: assert property (go && (req_cmd == `CMD_ACT ||
		req_cmd == `CMD_MRS) |=> addr == $past(req_addr)) else $error("row wrong");
	column_a: assert property (rw |=>
		addr[9:0] == $past(req_addr[9:0])) else $error("column wrong");
	auto_close_a: assert property (rw |=>
		addr[10] == $past(req_auto_close)) else $error("close bit wrong");
	all_banks_a: assert property (go && req_cmd == `CMD_PRE |=>
		addr[10] == $past(req_all_banks)) else $error("all bit wrong");
	shorten_a: assert property (rw |=>
		addr[12] != $past(chop)) else $error("chop bit wrong");
	write_mask_a: assert property (wdata_take |=>
		{upper_lane_write_mask, lower_lane_write_mask} == ~$past(wkeep))
		else $error("mask wrong");
	reset_pin_a: assert property (1'b1 |=>
		reset_n != $past(dev_reset_req)) else $error("reset pin wrong");
	cover property (rw && chop);
	cover property (wdata_take && wkeep == 2'h0);
	cover property (go && req_cmd == `CMD_MRS);
endmodule
bind sdram_host sdram_host_properties #(.BW(BW), .AW(AW)) chk (.*);
`default_nettype wire

// File: sdram_dev_model.sv
// Behavioural memory device answering the controller's pins
`timescale 1ns/1ps
`default_nettype none
module sdram_dev_model (
	// Command pins
	input  wire        link_clk_t,
	input  wire [3:0]  cmd,
	input  wire [14:0] addr,
	input  wire        reset_n,
	// Lane pins, lower lane in the low bits
	input  wire [15:0] dq_host,
	input  wire [1:0]  dq_oe,
	input  wire [1:0]  mask,
	input  wire [1:0]  dqs_oe,
	input  wire [1:0]  dqs_host,
	output wire [15:0] dq_in,
	output wire [1:0]  dqs_in
);
	logic [15:0] mem [0:15];
	logic [15:0] drv = 16'h0000;
	logic        dqs = 1'b0;
	logic [3:0]  col;
	logic [3:0]  wcol;
	logic [3:0]  wcnt = 4'h0;
	int          i;
	// Wire levels; released data shows the inverted residue
	assign dq_in[7:0] = dq_oe[0] ? dq_host[7:0] : drv[7:0];
	assign dq_in[15:8] = dq_oe[1] ? dq_host[15:8] : drv[15:8];
	assign dqs_in[0] = dqs_oe[0] ? dqs_host[0] : dqs;
	assign dqs_in[1] = dqs_oe[1] ? dqs_host[1] : dqs;
	// Low reset loses the array
	always @(negedge reset_n) begin
		for (i = 0; i < 16; i++)
			mem[i] = 16'h0000;
	end
	// Commands on the true clock's rise; deselect never matches
	always @(posedge link_clk_t) begin
		if (reset_n && cmd == 4'h4) begin
			wcol = addr[3:0];
			wcnt = addr[12] ? 4'h8 : 4'h4;
		end
		if (reset_n && cmd == 4'h5) begin
			col = addr[3:0];
			repeat (addr[12] ? 8 : 4) begin
				drv = mem[col];
				dqs = ~dqs;
				col = col + 4'h1;
				@(link_clk_t);
			end
			drv = ~drv;
		end
	end
	// Write beats taken mid-beat; a high mask drops that byte
	always @(link_clk_t) begin
		#25;
		if (wcnt != 4'h0 && dqs_oe[0] && dq_oe[0]) begin
			wcnt = wcnt - 4'h1;
			if (!mask[0])
				mem[wcol][7:0] = dq_host[7:0];
			if (!mask[1])
				mem[wcol][15:8] = dq_host[15:8];
			wcol = wcol + 4'h1;
		end
	end
endmodule
`default_nettype wire

// File: sdram_host_tb_top.sv
// Testbench for the memory controller
`timescale 1ns/1ps
`default_nettype none
module sdram_host_tb_top;
	logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_auto_close = 1'b0;
	logic req_all_banks = 1'b0, req_chop = 1'b0, chop_enable = 1'b0;
	logic dev_reset_req = 1'b0, rd_on = 1'b0, wiped = 1'b0;
	logic [3:0] req_cmd = 4'h7, c, f;
	logic [2:0] req_bank = 3'h0, b;
	logic [14:0] req_addr = 15'h0000, a, e, m;
	logic [15:0] wdata = 16'h0000;
	logic [1:0] wkeep = 2'h0;
	int bad_count = 0, compares = 0, rk = 0, wk = 0, k;
	wire req_ready, wdata_take, rdata_valid, link_clk_t, link_clk_c;
	wire cs_n, ras_n, cas_n, we_n, reset_n;
	wire [2:0] bank;
	wire [14:0] addr;
	wire [15:0] rdata;
	wire [7:0] lower_lane_data_in, lower_lane_data_out;
	wire [7:0] upper_lane_data_in, upper_lane_data_out;
	wire lower_lane_data_oe, lower_lane_write_mask, lower_lane_strobe_in;
	wire lower_lane_strobe_t_out, lower_lane_strobe_c_out, lower_lane_strobe_oe;
	wire upper_lane_data_oe, upper_lane_write_mask, upper_lane_strobe_in;
	wire upper_lane_strobe_t_out, upper_lane_strobe_c_out, upper_lane_strobe_oe;
	// Rows: command, bank, address, flags {close,all,chop,chop on}, address out
	logic [40:0] rows [0:6] = '{
		{4'h3, 3'h5, 15'h7FFF, 4'h0, 15'h7FFF},
		{4'h0, 3'h2, 15'h1234, 4'h0, 15'h1234},
		{4'h2, 3'h6, 15'h0000, 4'h4, 15'h0400},
		{4'h2, 3'h1, 15'h7FFF, 4'h0, 15'h0000},
		{4'h5, 3'h1, 15'h7FFF, 4'h8, 15'h17FF},
		{4'h5, 3'h7, 15'h0155, 4'h3, 15'h0155},
		{4'h4, 3'h0, 15'h0000, 4'h2, 15'h1000}};
	sdram_host dut (.*);
	sdram_dev_model mem_dev (.link_clk_t, .addr, .reset_n,
		.cmd({cs_n, ras_n, cas_n, we_n}),
		.dq_host({upper_lane_data_out, lower_lane_data_out}),
		.dq_oe({upper_lane_data_oe, lower_lane_data_oe}),
		.mask({upper_lane_write_mask, lower_lane_write_mask}),
		.dqs_oe({upper_lane_strobe_oe, lower_lane_strobe_oe}),
		.dqs_host({upper_lane_strobe_t_out, lower_lane_strobe_t_out}),
		.dq_in({upper_lane_data_in, lower_lane_data_in}),
		.dqs_in({upper_lane_strobe_in, lower_lane_strobe_in}));
	always #5 clk = ~clk;
	task automatic check(input string what, input logic [15:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task complete_run;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Kept bytes of write beat n, or zero once the array is lost
	function automatic logic [15:0] expd(input int n);
		expd = {n[1] ? {4'hC, n[3:0]} : 8'h00, n[0] ? {4'h5, n[3:0]} : 8'h00};
		if (wiped)
			expd = 16'h0000;
	endfunction
	// Holds a request until the controller takes it
	task automatic issue(input logic [3:0] cc, input logic [2:0] bb,
		input logic [14:0] aa, input logic [3:0] ff);
		int t;
		{req_auto_close, req_all_banks, req_chop, chop_enable} = ff;
		req_cmd = cc;
		req_bank = bb;
		req_addr = aa;
		req_valid = 1'b1;
		for (t = 0; t < 500 && req_ready !== 1'b1; t++)
			@(negedge clk);
		if (t == 500)
			bad_count++;
		@(negedge clk);
		req_valid = 1'b0;
	endtask
	task automatic read_beats(input logic [3:0] fl, input int n);
		int t;
		rk = 0;
		rd_on = 1'b1;
		issue(4'h5, 3'h0, 15'h0000, fl);
		for (t = 0; t < 200 && rk < 8; t++)
			@(negedge clk);
		check("beats", 16'(rk), 16'(n));
		rd_on = 1'b0;
	endtask
	// Beat data and keep flags follow the count of taken beats
	always @(posedge clk)
		if (wdata_take === 1'b1)
			wk <= wk + 1;
	always @(negedge clk) begin
		wdata <= {4'hC, wk[3:0], 4'h5, wk[3:0]};
		wkeep <= wk[1:0];
	end
	// Read beats are compared in arrival order
	always @(negedge clk)
		if (rd_on && rdata_valid === 1'b1) begin
			check("rdata", rdata, expd(rk));
			rk++;
		end
	// Differential pairs stay complementary
	wire [1:0] st_t = {upper_lane_strobe_t_out, lower_lane_strobe_t_out};
	wire [1:0] st_c = {upper_lane_strobe_c_out, lower_lane_strobe_c_out};
	always @(negedge clk)
		if (!rst) begin
			check("clk_pair", link_clk_c, !link_clk_t);
			check("strobe_pair", st_c, 2'(~st_t));
		end
	// Main sequence
	initial begin
		repeat (16) @(negedge clk);
		check("idle", {cs_n, ras_n, cas_n, we_n, reset_n}, 5'h1E);
		rst = 1'b0;
		for (k = 0; k < 7; k++) begin
			{c, b, a, f, e} = rows[k];
			m = (c == 4'h2) ? 15'h0400 : 15'h7FFF;
			issue(c, b, a, f);
			check("cmd", {cs_n, ras_n, cas_n, we_n}, c);
			check("bank", bank, b);
			check("addr", addr & m, e & m);
		end
		issue(4'h4, 3'h0, 15'h0000, 4'h0);
		wk = 0; // Beats of this burst count from zero
		read_beats(4'h0, 8);
		read_beats(4'h3, 4);
		dev_reset_req = 1'b1;
		repeat (2) @(negedge clk);
		check("reset", {reset_n, req_ready}, 2'h0);
		dev_reset_req = 1'b0;
		repeat (2) @(negedge clk);
		check("reset_n", reset_n, 1'b1);
		wiped = 1'b1;
		read_beats(4'h0, 8);
		complete_run();
	end
	// Watchdog
	initial begin
		#100000;
		bad_count++;
		complete_run();
	end
endmodule
`default_nettype wire
